// file: logic/dus_top.v
// AXI4-Lite register block for a two channel serial transceiver setup and output port
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "dus_map.vh"
// Functional notes
// - Negate bits drive outputs high
// - Assert bits drive outputs low
// - Alternate function outputs ignore assert/negate
// - Commands reset receiver and transmitter; the error reset code is not decoded
// - Pointer commands select mode zero/one
// - Mode writes advance the pointer, which stops at mode two
// - Mode zero zero picks normal table
// - Mode one 0x13: eight bits, no parity
// - Mode two 0x07: normal, one stop
// - Enable codes: both, or transmitter only
// - Clock nibbles pick receive/transmit sources
// - Idle status reads ready and empty
// - Mode one bit7 drives automatic rts
// - Mode two 0x17 gates on cts
// - Aux 0x40 selects timer on input two
// - Config 0x06 routes timer and clock
// - Mode one 0x1b sets tag one
// - Data may follow address immediately
module dus_top #(
    parameter DEPTH = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [6:0] multi_in,
    output reg [7:0] multi_out,
    output reg chan_a_tx_tag,
    output reg chan_b_tx_tag
);
    reg [7:0] aw_addr;
    reg aw_have;
    reg [7:0] w_data;
    reg w_have;
    reg w_strb_low;
    reg [7:0] aux_control;
    reg [7:0] timer_preload_high;
    reg [7:0] timer_preload_low;
    reg [7:0] output_config;
    reg [7:0] port_bits;
    reg start_pulse;
    reg stop_pulse;
    reg clk1x_a;
    reg [3:0] div_a;
    wire [7:0] mode_zero_a;
    wire [7:0] mode_one_a;
    wire [7:0] mode_two_a;
    wire [7:0] clock_a;
    wire [7:0] status_a;
    wire rts_a_n;
    wire tag_a;
    wire [7:0] mode_zero_b;
    wire [7:0] mode_one_b;
    wire [7:0] mode_two_b;
    wire [7:0] clock_b;
    wire [7:0] status_b;
    wire rts_b_n;
    wire tag_b;
    wire timer_wave;
    wire [7:0] output_negate_bits = w_data;
    wire [7:0] output_assert_bits = w_data;
    wire do_write = aw_have && w_have && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire wr_sel_hit;

    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    function known;
        input [7:0] a;
        begin
            known = hit(a, `DUS_OFF_CMD_A) || hit(a, `DUS_OFF_MODE_A) || hit(a, `DUS_OFF_CLK_A)
                || hit(a, `DUS_OFF_STAT_A) || hit(a, `DUS_OFF_TX_A) || hit(a, `DUS_OFF_CMD_B)
                || hit(a, `DUS_OFF_MODE_B) || hit(a, `DUS_OFF_CLK_B) || hit(a, `DUS_OFF_STAT_B)
                || hit(a, `DUS_OFF_TX_B) || hit(a, `DUS_OFF_AUX) || hit(a, `DUS_OFF_PRE_HI)
                || hit(a, `DUS_OFF_PRE_LO) || hit(a, `DUS_OFF_START) || hit(a, `DUS_OFF_STOP)
                || hit(a, `DUS_OFF_OUT_CFG) || hit(a, `DUS_OFF_OUT_SET) || hit(a, `DUS_OFF_OUT_NEG)
                || hit(a, `DUS_OFF_OUT_STATE);
        end
    endfunction

    // Only the low byte lane carries register data
    assign wr_sel_hit = do_write && w_strb_low;

    dus_channel #(
        .DEPTH(DEPTH)
    ) u_chan_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .cmd_we(wr_sel_hit && hit(aw_addr, `DUS_OFF_CMD_A)),
        .mode_we(wr_sel_hit && hit(aw_addr, `DUS_OFF_MODE_A)),
        .clk_we(wr_sel_hit && hit(aw_addr, `DUS_OFF_CLK_A)),
        .tx_we(wr_sel_hit && hit(aw_addr, `DUS_OFF_TX_A)),
        .wdata(w_data),
        .cts_n(multi_in[0]),
        .mode_zero(mode_zero_a),
        .mode_one(mode_one_a),
        .mode_two(mode_two_a),
        .clock_select(clock_a),
        .status(status_a),
        .rts_n(rts_a_n),
        .tx_tag(tag_a)
    );

    dus_channel #(
        .DEPTH(DEPTH)
    ) u_chan_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .cmd_we(wr_sel_hit && hit(aw_addr, `DUS_OFF_CMD_B)),
        .mode_we(wr_sel_hit && hit(aw_addr, `DUS_OFF_MODE_B)),
        .clk_we(wr_sel_hit && hit(aw_addr, `DUS_OFF_CLK_B)),
        .tx_we(wr_sel_hit && hit(aw_addr, `DUS_OFF_TX_B)),
        .wdata(w_data),
        .cts_n(multi_in[1]),
        .mode_zero(mode_zero_b),
        .mode_one(mode_one_b),
        .mode_two(mode_two_b),
        .clock_select(clock_b),
        .status(status_b),
        .rts_n(rts_b_n),
        .tx_tag(tag_b)
    );

    dus_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .aux(aux_control),
        .preload({timer_preload_high, timer_preload_low}),
        .start(start_pulse),
        .stop(stop_pulse),
        .tick_in(multi_in[2]),
        .wave(timer_wave)
    );

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= 8'h00;
            aw_have <= 1'b0;
            w_data <= 8'h00;
            w_have <= 1'b0;
            w_strb_low <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DUS_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
                aw_have <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata[7:0];
                w_strb_low <= s_axi_wstrb[0];
                w_have <= 1'b1;
            end
            if (do_write) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known(aw_addr) ? `DUS_RESP_OKAY : `DUS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Setup registers and output port latch
    always @(posedge aclk) begin
        if (!aresetn) begin
            aux_control <= 8'h00;
            timer_preload_high <= 8'h00;
            timer_preload_low <= 8'h00;
            output_config <= 8'h00;
            port_bits <= `DUS_OUT_RESET;
        end else if (wr_sel_hit) begin
            if (hit(aw_addr, `DUS_OFF_AUX)) begin
                aux_control <= w_data;
            end
            if (hit(aw_addr, `DUS_OFF_PRE_HI)) begin
                timer_preload_high <= w_data;
            end
            if (hit(aw_addr, `DUS_OFF_PRE_LO)) begin
                timer_preload_low <= w_data;
            end
            if (hit(aw_addr, `DUS_OFF_OUT_CFG)) begin
                output_config <= w_data;
            end
            if (hit(aw_addr, `DUS_OFF_OUT_SET)) begin
                port_bits <= port_bits & ~output_assert_bits;
            end
            if (hit(aw_addr, `DUS_OFF_OUT_NEG)) begin
                port_bits <= port_bits | output_negate_bits;
            end
        end
    end

    // Channel A transmit 1X clock is aclk divided by 32 (toggles every 16 cycles)
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_a <= 4'h0;
            clk1x_a <= 1'b0;
        end else begin
            div_a <= div_a + 4'h1;
            if (div_a == 4'hf) begin
                clk1x_a <= !clk1x_a;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            multi_out <= `DUS_OUT_RESET;
            chan_a_tx_tag <= 1'b0;
            chan_b_tx_tag <= 1'b0;
        end else begin
            multi_out <= port_bits;
            if (mode_one_a[`DUS_BIT_AUTO_RTS]) begin
                multi_out[0] <= rts_a_n;
            end
            if (mode_one_b[`DUS_BIT_AUTO_RTS]) begin
                multi_out[1] <= rts_b_n;
            end
            if (output_config[1:0] == `DUS_OP2_TX1X) begin
                multi_out[2] <= clk1x_a;
            end
            if (output_config[3:2] == `DUS_OP3_TIMER) begin
                multi_out[3] <= timer_wave;
            end
            chan_a_tx_tag <= tag_a;
            chan_b_tx_tag <= tag_b;
        end
    end

    // Read channel; start and stop are side effects of reads
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DUS_RESP_OKAY;
            start_pulse <= 1'b0;
            stop_pulse <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            start_pulse <= do_read && hit(s_axi_araddr, `DUS_OFF_START);
            stop_pulse <= do_read && hit(s_axi_araddr, `DUS_OFF_STOP);
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= known(s_axi_araddr) ? `DUS_RESP_OKAY : `DUS_RESP_SLVERR;
                case ({s_axi_araddr[7:2], 2'b00})
                    `DUS_OFF_STAT_A: s_axi_rdata <= {24'h000000, status_a};
                    `DUS_OFF_STAT_B: s_axi_rdata <= {24'h000000, status_b};
                    `DUS_OFF_CLK_A: s_axi_rdata <= {24'h000000, clock_a};
                    `DUS_OFF_CLK_B: s_axi_rdata <= {24'h000000, clock_b};
                    `DUS_OFF_MODE_A: s_axi_rdata <= {8'h00, mode_two_a, mode_one_a, mode_zero_a};
                    `DUS_OFF_MODE_B: s_axi_rdata <= {8'h00, mode_two_b, mode_one_b, mode_zero_b};
                    `DUS_OFF_AUX: s_axi_rdata <= {24'h000000, aux_control};
                    `DUS_OFF_OUT_STATE: s_axi_rdata <= {24'h000000, multi_out};
                    default: s_axi_rdata <= 32'h00000000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // dus_top

// file: logic/dus_map.vh
// Register map, command codes and field positions for the dual serial channel setup block
`ifndef DUS_MAP_VH
`define DUS_MAP_VH
`define DUS_OFF_CMD_A 8'h00
`define DUS_OFF_MODE_A 8'h04
`define DUS_OFF_CLK_A 8'h08
`define DUS_OFF_STAT_A 8'h0c
`define DUS_OFF_TX_A 8'h10
`define DUS_OFF_CMD_B 8'h20
`define DUS_OFF_MODE_B 8'h24
`define DUS_OFF_CLK_B 8'h28
`define DUS_OFF_STAT_B 8'h2c
`define DUS_OFF_TX_B 8'h30
`define DUS_OFF_AUX 8'h40
`define DUS_OFF_PRE_HI 8'h44
`define DUS_OFF_PRE_LO 8'h48
`define DUS_OFF_START 8'h4c
`define DUS_OFF_STOP 8'h50
`define DUS_OFF_OUT_CFG 8'h54
`define DUS_OFF_OUT_SET 8'h58
`define DUS_OFF_OUT_NEG 8'h5c
`define DUS_OFF_OUT_STATE 8'h60
`define DUS_CMD_RX_RESET 4'h2
`define DUS_CMD_TX_RESET 4'h3
`define DUS_CMD_ERR_RESET 4'h4
`define DUS_CMD_PTR_ZERO 4'hb
`define DUS_CMD_PTR_ONE 4'h1
`define DUS_CMD_RTS_ON 4'h8
`define DUS_CMD_RTS_OFF 4'h9
`define DUS_EN_RX_ON 2'h1
`define DUS_EN_TX_ON 2'h1
`define DUS_PTR_ZERO 2'h0
`define DUS_PTR_ONE 2'h1
`define DUS_PTR_TWO 2'h2
`define DUS_MODE_ONE_RESET 8'h00
`define DUS_MODE_TWO_RESET 8'h00
`define DUS_CLK_XTAL_9600 4'hb
`define DUS_CLK_IN4_16X 4'he
`define DUS_CLK_IN5_1X 4'hf
`define DUS_BIT_AUTO_RTS 7
`define DUS_BIT_AUTO_CTS 4
`define DUS_BIT_TAG 3
`define DUS_BIT_TIMER_MODE 6
`define DUS_BIT_BAUD_SET 7
`define DUS_STAT_TX_RDY 2
`define DUS_STAT_TX_EMPTY 3
`define DUS_STAT_RX_RDY 0
`define DUS_OUT_RESET 8'hff
`define DUS_RESP_OKAY 2'b00
`define DUS_RESP_SLVERR 2'b10
`define DUS_OP2_TX1X 2'h2
`define DUS_OP3_TIMER 2'h1
`define DUS_CHAR_CYCLES 16'd10
`endif

// file: logic/dus_channel.v
// One serial channel: command decode, mode pointer, clock select, tagged transmit holding
`timescale 1ns/1ps
`include "dus_map.vh"
module dus_channel #(
    parameter DEPTH = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire cmd_we,
    input wire mode_we,
    input wire clk_we,
    input wire tx_we,
    input wire [7:0] wdata,
    input wire cts_n,
    output reg [7:0] mode_zero,
    output reg [7:0] mode_one,
    output reg [7:0] mode_two,
    output reg [7:0] clock_select,
    output reg [7:0] status,
    output reg rts_n,
    output reg tx_tag
);
    reg [1:0] ptr;
    reg rx_on;
    reg tx_on;
    reg [3:0] count;
    reg [15:0] busy;
    reg [8:0] fifo [0:DEPTH-1];
    reg [3:0] rd;
    reg [3:0] wr;
    wire [3:0] cmd = wdata[7:4];
    wire full = (count == DEPTH);
    wire tx_empty = (count == 4'h0) && (busy == 16'd0);
    wire cts_ok = !mode_two[`DUS_BIT_AUTO_CTS] || !cts_n;
    integer i;
    always @(posedge aclk) begin
        if (!aresetn) begin
            ptr <= `DUS_PTR_ONE;
            rx_on <= 1'b0;
            tx_on <= 1'b0;
            mode_zero <= 8'h00;
            mode_one <= `DUS_MODE_ONE_RESET;
            mode_two <= `DUS_MODE_TWO_RESET;
            clock_select <= 8'h00;
            count <= 4'h0;
            busy <= 16'd0;
            rd <= 4'h0;
            wr <= 4'h0;
            rts_n <= 1'b1;
            tx_tag <= 1'b0;
            status <= 8'h00;
            for (i = 0; i < DEPTH; i = i + 1) begin
                fifo[i] <= 9'h000;
            end
        end else begin
            if (cmd_we) begin
                if (cmd == `DUS_CMD_RX_RESET) begin
                    rx_on <= 1'b0;
                end else if (cmd == `DUS_CMD_TX_RESET) begin
                    tx_on <= 1'b0;
                end else if (cmd == `DUS_CMD_PTR_ZERO) begin
                    ptr <= `DUS_PTR_ZERO;
                end else if (cmd == `DUS_CMD_PTR_ONE) begin
                    ptr <= `DUS_PTR_ONE;
                end else if (cmd == `DUS_CMD_RTS_ON) begin
                    rts_n <= 1'b0;
                end else if (cmd == `DUS_CMD_RTS_OFF) begin
                    rts_n <= 1'b1;
                end
                if (cmd == 4'h0 && wdata[3:0] != 4'h0) begin
                    rx_on <= wdata[0];
                    tx_on <= wdata[2];
                end
            end
            if (mode_we) begin
                case (ptr)
                    `DUS_PTR_ZERO: mode_zero <= wdata;
                    `DUS_PTR_ONE: mode_one <= wdata;
                    default: mode_two <= wdata;
                endcase
                if (ptr != `DUS_PTR_TWO) begin
                    ptr <= ptr + 2'h1;
                end
            end
            if (clk_we) begin
                clock_select <= wdata;
            end
            if (tx_we && tx_on && !full) begin
                fifo[wr[2:0]] <= {mode_one[`DUS_BIT_TAG], wdata};
                wr <= wr + 4'h1;
            end
            if (busy != 16'd0) begin
                busy <= busy - 16'd1;
            end else if (count != 4'h0 && cts_ok) begin
                busy <= `DUS_CHAR_CYCLES;
                tx_tag <= fifo[rd[2:0]][8];
                rd <= rd + 4'h1;
            end
            count <= count + {3'h0, tx_we && tx_on && !full}
                - {3'h0, busy == 16'd0 && count != 4'h0 && cts_ok};
            // transmitter reset empties the queue; placed last so it wins
            if (cmd_we && cmd == `DUS_CMD_TX_RESET) begin
                count <= 4'h0;
                busy <= 16'd0;
                rd <= 4'h0;
                wr <= 4'h0;
            end
            if (mode_one[`DUS_BIT_AUTO_RTS]) begin
                rts_n <= !rx_on;
            end
            status <= {4'h0, tx_empty && tx_on, !full && tx_on, 2'b00};
        end
    end
endmodule // dus_channel

// file: logic/dus_timer.v
// Counter/timer: preload, start, stop, square wave output
`timescale 1ns/1ps
`include "dus_map.vh"
module dus_timer (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] aux,
    input wire [15:0] preload,
    input wire start,
    input wire stop,
    input wire tick_in,
    output reg wave
);
    reg run;
    reg [15:0] cnt;
    reg tick_d;
    wire tick = tick_in && !tick_d;
    always @(posedge aclk) begin
        if (!aresetn) begin
            run <= 1'b0;
            cnt <= 16'd0;
            tick_d <= 1'b0;
            wave <= 1'b1;
        end else begin
            tick_d <= tick_in;
            if (start) begin
                run <= 1'b1;
                cnt <= preload;
            end else if (stop && !aux[`DUS_BIT_TIMER_MODE]) begin
                run <= 1'b0;
                wave <= 1'b1;
            end else if (run && tick) begin
                if (cnt == 16'd0) begin
                    cnt <= preload;
                    wave <= aux[`DUS_BIT_TIMER_MODE] ? !wave : 1'b0;
                end else begin
                    cnt <= cnt - 16'd1;
                end
            end
        end
    end
endmodule // dus_timer

// file: bench/dus_peer.sv
// Remote serial peer model: clear-to-send levels and external clock inputs
`timescale 1ns/1ps
module dus_peer (
    input wire aclk,
    input wire cts_a_n,
    input wire cts_b_n,
    input wire clk_en,
    output wire [6:0] multi_in
);
    reg [1:0] div = 2'h0;
    always @(posedge aclk) begin
        div <= div + 2'h1;
    end
    assign multi_in[1:0] = {cts_b_n, cts_a_n};
    // clocks on inputs two, four, five
    // Clocks stand low while disabled, so no edge is seen by accident
    assign multi_in[2] = clk_en & div[1];
    assign multi_in[3] = 1'b1;
    assign multi_in[4] = clk_en & div[1];
    assign multi_in[5] = clk_en & div[0];
    assign multi_in[6] = 1'b1;
endmodule // dus_peer

// file: bench/dus_top_sva.sv
// Concurrent checks on the register bus and output port of the setup block
`timescale 1ns/1ps
`include "dus_map.vh"
module dus_top_sva #(
    parameter DEPTH = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] multi_out,
    input wire chan_a_tx_tag,
    input wire chan_b_tx_tag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_b_after_take: assert property (s_wr_take |=> ##1 s_axi_bvalid)
        else $error("write response missing after address and data taken");
    a_r_after_take: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read data missing after address taken");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than one cycle");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `DUS_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned nonzero data");
    a_out_reset: assert property ($rose(aresetn) |-> multi_out == `DUS_OUT_RESET && !chan_a_tx_tag && !chan_b_tx_tag)
        else $error("outputs not at reset level");
    a_gp_by_write: assert property (!$stable(multi_out[7:4]) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
        else $error("general outputs changed without a write");
    cover property (s_wr_take ##1 s_axi_bvalid);
endmodule // dus_top_sva
bind dus_top dus_top_sva #(.DEPTH(DEPTH)) u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .multi_out(multi_out), .chan_a_tx_tag(chan_a_tx_tag), .chan_b_tx_tag(chan_b_tx_tag));

// file: bench/tb_dual_uart_channel_setup.sv
// Self-checking bench for the dual serial channel setup block
`timescale 1ns/1ps
`include "dus_map.vh"
module tb_dual_uart_channel_setup;
    typedef struct packed { logic rd; logic [7:0] addr; logic [31:0] val; } dus_row_t;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic cts_a_n, cts_b_n, clk_en, chan_a_tx_tag, chan_b_tx_tag, saw;
    logic [7:0] awaddr, araddr, multi_out;
    logic [31:0] wdata, rdata, rdat;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    wire [6:0] multi_in;
    int error_cnt = 0;
    int n_tests = 0;
    int cnt, n;
    // Channel A bring-up, then flow control and clock selects
    dus_row_t rows [20] = '{'{0, 8'h00, 32'h20}, '{0, 8'h00, 32'h30}, '{0, 8'h00, 32'h40}, '{0, 8'h00, 32'hb0},
        '{0, 8'h04, 32'h00}, '{0, 8'h04, 32'h13}, '{0, 8'h04, 32'h07}, '{0, 8'h08, 32'hbb}, '{0, 8'h00, 32'h05},
        '{1, 8'h0c, 32'h0c}, '{1, 8'h04, 32'h071300}, '{1, 8'h08, 32'hbb}, '{0, 8'h00, 32'h10},
        '{0, 8'h04, 32'h93}, '{0, 8'h04, 32'h17}, '{1, 8'h04, 32'h179300}, '{0, 8'h28, 32'hbf},
        '{1, 8'h28, 32'hbf}, '{0, 8'h08, 32'heb}, '{1, 8'h08, 32'heb}};
    dus_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .multi_in(multi_in),
        .multi_out(multi_out), .chan_a_tx_tag(chan_a_tx_tag), .chan_b_tx_tag(chan_b_tx_tag));
    dus_peer peer (.aclk(aclk), .cts_a_n(cts_a_n), .cts_b_n(cts_b_n), .clk_en(clk_en), .multi_in(multi_in));
    task automatic close_out();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 50);
        bready <= 1'b0;
        resp = bresp;
        if (k >= 50) error_cnt++;
        // Outputs are registered one edge after the write lands
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        int k;
        k = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 50);
        rready <= 1'b0;
        rdat = rdata;
        resp = rresp;
        if (k >= 50) error_cnt++;
    endtask
    task automatic edges(input int b, input int cyc, output int c);
        logic p;
        c = 0;
        p = multi_out[b];
        repeat (cyc) begin
            @(posedge aclk);
            if (multi_out[b] !== p) c++;
            p = multi_out[b];
        end
    endtask
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // Bound well above the thousand or so cycles the sequence needs
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        close_out();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, clk_en, cts_b_n} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        cts_a_n = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk("out_reset", 32'hff, {24'h0, multi_out});
        for (int i = 0; i < 20; i++) begin
            if (rows[i].rd) begin
                rd(rows[i].addr);
                chk("row_read", rows[i].val, rdat);
            end else begin
                wr(rows[i].addr, rows[i].val);
                chk("row_resp", {30'h0, `DUS_RESP_OKAY}, {30'h0, resp});
            end
        end
        chk("rts_a", 32'h0, {31'h0, multi_out[0]});
        wr(`DUS_OFF_TX_A, 32'h5a);
        repeat (30) @(posedge aclk);
        rd(`DUS_OFF_STAT_A);
        chk("stat_a_blocked", 32'h0, {31'h0, rdat[`DUS_STAT_TX_EMPTY]});
        cts_a_n <= 1'b0;
        repeat (30) @(posedge aclk);
        rd(`DUS_OFF_STAT_A);
        chk("stat_a_sent", 32'h0c, rdat);
        chk("tag_a", 32'h0, {31'h0, chan_a_tx_tag});
        // assert then negate, strobe-less write ignored
        wr(`DUS_OFF_OUT_SET, 32'hf2);
        chk("out_asserted", 32'h00, {24'h0, multi_out & 8'hf2});
        wr(`DUS_OFF_OUT_NEG, 32'h30);
        chk("out_negated", 32'h30, {24'h0, multi_out & 8'hf2});
        wstrb <= 4'he;
        wr(`DUS_OFF_OUT_SET, 32'hff);
        wstrb <= 4'hf;
        chk("out_no_strobe", 32'h30, {24'h0, multi_out & 8'hf2});
        // timer loaded and started before it is routed
        clk_en <= 1'b1;
        wr(`DUS_OFF_AUX, 32'h40);
        wr(`DUS_OFF_PRE_HI, 32'h00);
        wr(`DUS_OFF_PRE_LO, 32'h05);
        rd(`DUS_OFF_START);
        wr(`DUS_OFF_OUT_CFG, 32'h06);
        wr(`DUS_OFF_OUT_SET, 32'h0c);
        edges(3, 300, cnt);
        chk("op3_timer", 32'h1, {31'h0, cnt > 0});
        edges(2, 300, cnt);
        chk("op2_clock", 32'h1, {31'h0, cnt > 0});
        chk("out_kept", 32'h30, {24'h0, multi_out & 8'hf0});
        // data loaded right behind the tagged address
        saw = 1'b0;
        fork
            begin
                wr(`DUS_OFF_CMD_B, 32'h10);
                wr(`DUS_OFF_MODE_B, 32'h1b);
                wr(`DUS_OFF_CMD_B, 32'h04);
                wr(`DUS_OFF_TX_B, 32'h41);
                wr(`DUS_OFF_CMD_B, 32'h10);
                wr(`DUS_OFF_MODE_B, 32'h13);
                wr(`DUS_OFF_TX_B, 32'h55);
            end
            repeat (60) begin
                @(posedge aclk);
                if (chan_b_tx_tag === 1'b1) saw = 1'b1;
            end
        join
        chk("tag_address", 32'h1, {31'h0, saw});
        chk("tag_data", 32'h0, {31'h0, chan_b_tx_tag});
        n = 0;
        do begin
            rd(`DUS_OFF_STAT_B);
            n++;
        end while (rdat !== 32'h0c && n < 40);
        chk("stat_b_idle", 32'h0c, rdat);
        wr(8'hfc, 32'h0);
        chk("bad_wr_resp", {30'h0, `DUS_RESP_SLVERR}, {30'h0, resp});
        rd(8'hfc);
        chk("bad_rd_resp", {30'h0, `DUS_RESP_SLVERR}, {30'h0, resp});
        chk("bad_rd_data", 32'h0, rdat);
        // Reset in mid-run: outputs released, pointer back on mode one
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("out_rerst", 32'hff, {24'h0, multi_out});
        aresetn <= 1'b1;
        wr(`DUS_OFF_MODE_A, 32'haa);
        rd(`DUS_OFF_MODE_A);
        chk("mode_after_rst", 32'h0000aa00, rdat);
        close_out();
    end
endmodule // tb_dual_uart_channel_setup
